//--- arith_host_port.sv
// host-side bus port of a stack arithmetic coprocessor
// assumes strobes, select and acknowledges arrive asynchronously and are
// synchronised here; the arithmetic engine is modelled by a busy timer
module arith_host_port #(
  parameter int unsigned EXEC_CYCLES = arith_port_pkg::EXEC_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cmd_data_i,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  output logic wait_n_o,
  output logic done_n_o,
  output logic done_n_oe_o,
  input wire logic completion_ack_n_i,
  output logic service_request_out_o,
  input wire logic service_ack_in_n_i
);
  import arith_port_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  logic [7:0] data1_ff;
  logic [7:0] data2_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 7'h3f;
      sync2_ff <= 7'h3f;
      data1_ff <= 8'h00;
      data2_ff <= 8'h00;
    end else begin
      sync1_ff <= {reset_i, cs_n_i, rd_n_i, wr_n_i, cmd_data_i, completion_ack_n_i, service_ack_in_n_i};
      sync2_ff <= sync1_ff;
      data1_ff <= host_data_lines_i;
      data2_ff <= data1_ff;
    end
  end

  wire dev_reset = sync2_ff[6];
  wire cs_n_s = sync2_ff[5];
  wire rd_n_s = sync2_ff[4];
  wire wr_n_s = sync2_ff[3];
  wire cd_s = sync2_ff[2];
  wire completion_ack_n_n_s = sync2_ff[1];
  wire sack_n_s = sync2_ff[0];

  //////////////////////////////////////////////////////////////////////////
  // strobe edge detection on the synchronised copies
  logic rd_n_d_ff;
  logic wr_n_d_ff;
  logic cs_n_d_ff;
  logic cs_armed_ff;

  wire can_start = !cs_n_s && (cs_armed_ff || cs_n_d_ff);
  // both strobes low is undefined, so neither is taken
  wire both_low = !rd_n_s && !wr_n_s;
  wire rd_fall = rd_n_d_ff && !rd_n_s && can_start && !both_low;
  wire wr_fall = wr_n_d_ff && !wr_n_s && can_start && !both_low;
  wire wr_rise = !wr_n_d_ff && wr_n_s;
  wire rd_rise = !rd_n_d_ff && rd_n_s;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_n_d_ff <= 1'b1;
      wr_n_d_ff <= 1'b1;
      cs_n_d_ff <= 1'b1;
      cs_armed_ff <= 1'b0;
    end else begin
      rd_n_d_ff <= rd_n_s;
      wr_n_d_ff <= wr_n_s;
      cs_n_d_ff <= cs_n_s;
      // an access is taken once per select fall; if its strobe falls in the select-fall cycle, a held select can start another
      if (cs_n_s) begin
        cs_armed_ff <= 1'b0;
      end else if (cs_n_d_ff) begin
        cs_armed_ff <= 1'b1;
      end else if (rd_fall || wr_fall) begin
        cs_armed_ff <= 1'b0;
      end
    end
  end

  // transfer type from command/data line and read strobe
  xfer_type xfer;
  assign xfer = cd_s ? (rd_fall ? XFER_STATUS : XFER_CMD)
                     : (rd_fall ? XFER_POP : XFER_PUSH);

  //////////////////////////////////////////////////////////////////////////
  // bus handshake state machine
  bus_state_type state_ff;
  bus_state_type nxt_state;
  logic busy_ff;
  logic cmd_pend_ff;
  logic [7:0] cmd_ff;
  // request bit of the command now running; a parked command may replace cmd_ff
  logic run_sreq_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] status_ff;
  logic [$clog2(EXEC_CYCLES+1)-1:0] exec_cnt_ff;

  wire exec_done = busy_ff && (exec_cnt_ff == '0);
  wire take_wr = (state_ff == BUS_IDLE) && wr_fall;
  wire take_rd = (state_ff == BUS_IDLE) && rd_fall;
  // a command written while busy is parked until the running one ends
  wire cmd_accept = (state_ff == BUS_WR_WAIT) && cmd_pend_ff && (!busy_ff || exec_done);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BUS_IDLE: begin
        if (take_wr) begin
          nxt_state = BUS_WR_WAIT;
        end else if (take_rd) begin
          nxt_state = BUS_RD_HOLD;
        end
      end
      BUS_WR_WAIT: begin
        if (!cmd_pend_ff || cmd_accept) begin
          nxt_state = BUS_WR_HOLD;
        end
      end
      BUS_WR_HOLD: begin
        if (wr_rise || wr_n_s) begin
          nxt_state = BUS_IDLE;
        end
      end
      BUS_RD_HOLD: begin
        if (rd_rise || rd_n_s) begin
          nxt_state = BUS_IDLE;
        end
      end
    endcase
  end

  // wait is low from strobe take until data is settled or command accepted
  assign wait_n_o = !((state_ff == BUS_WR_WAIT) || take_wr || take_rd);
  // write wait is two cycles when the device is free, never longer than needed

  //////////////////////////////////////////////////////////////////////////
  // operand stack
  wire push_s = take_wr && (xfer == XFER_PUSH);
  wire pop_s = take_rd && (xfer == XFER_POP);
  logic [7:0] top_byte;
  operand_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .push_i(push_s),
    .pop_i(pop_s),
    .wr_byte_i(data2_ff),
    .pop_shift_i(1'b0),
    .top_byte_o(top_byte),
    .stack_top_o()
  );

  //////////////////////////////////////////////////////////////////////////
  // command register, busy timer and status
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= BUS_IDLE;
      busy_ff <= 1'b0;
      cmd_pend_ff <= 1'b0;
      cmd_ff <= CMD_RST;
      run_sreq_ff <= 1'b0;
      exec_cnt_ff <= '0;
      status_ff <= STATUS_RST;
      rd_data_ff <= 8'h00;
    end else if (dev_reset) begin
      // device reset ends execution and clears status but keeps the command
      state_ff <= BUS_IDLE;
      busy_ff <= 1'b0;
      cmd_pend_ff <= 1'b0;
      exec_cnt_ff <= '0;
      status_ff <= STATUS_RST;
    end else begin
      state_ff <= nxt_state;
      if (take_wr && xfer == XFER_CMD) begin
        cmd_pend_ff <= 1'b1;
        cmd_ff <= data2_ff;
      end else if (cmd_accept) begin
        cmd_pend_ff <= 1'b0;
      end
      if (cmd_accept) begin
        busy_ff <= 1'b1;
        run_sreq_ff <= cmd_ff[SREQ_BIT];
        exec_cnt_ff <= ($clog2(EXEC_CYCLES+1))'(EXEC_CYCLES - 1);
      end else if (exec_done) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        exec_cnt_ff <= exec_cnt_ff - 1'b1;
      end
      status_ff[ST_BUSY] <= cmd_accept || (busy_ff && !exec_done);
      // read data captured at the strobe; msb of the top word leaves first
      if (take_rd) begin
        rd_data_ff <= (xfer == XFER_STATUS) ? status_ff : top_byte;
      end
    end
  end

  // data bus driven for as long as the read strobe is held
  assign host_data_lines_o = rd_data_ff;
  assign host_data_lines_oe_o = (state_ff == BUS_RD_HOLD) && !rd_n_s && !cs_n_s;

  //////////////////////////////////////////////////////////////////////////
  // completion and service request flags
  logic done_ff;
  logic sreq_ff;
  // clear after read fall or write rise with select low
  wire access_clr = take_rd || (wr_rise && !cs_n_s);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_ff <= 1'b0;
      sreq_ff <= 1'b0;
    end else if (dev_reset) begin
      done_ff <= 1'b0;
      sreq_ff <= 1'b0;
    end else begin
      // completion sets over an ack or access clear in the same cycle, so a held ack yields one pulse
      if (exec_done) begin
        done_ff <= 1'b1;
      end else if (!completion_ack_n_n_s || access_clr) begin
        done_ff <= 1'b0;
      end
      if (exec_done) begin
        sreq_ff <= run_sreq_ff;
      end else if (!sack_n_s) begin
        sreq_ff <= 1'b0;
      end
    end
  end

  // open-drain flag: pulled low while done, released otherwise
  assign done_n_o = 1'b0;
  assign done_n_oe_o = done_ff;
  assign service_request_out_o = sreq_ff;
endmodule : arith_host_port

//--- arith_port_monitor.sv
// checker: handshake and flag timing at the host port pins
// assumes one clock domain and the active-low asynchronous reset
module arith_port_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] host_data_lines_o,
  input wire logic host_data_lines_oe_o,
  input wire logic wait_n_o,
  input wire logic done_n_oe_o,
  input wire logic completion_ack_n_i,
  input wire logic service_request_out_o,
  input wire logic service_ack_in_n_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // pins pass two sync stages, so holds of four cycles reach the logic
  property p_done_pulse; (!completion_ack_n_i)[*4] ##0 done_n_oe_o |=> !done_n_oe_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done outlived ack");
  property p_sreq_ack; (!service_ack_in_n_i)[*4] |-> !service_request_out_o; endproperty
  a_sreq_ack: assert property (p_sreq_ack) else $error("sreq kept under ack");
  property p_read_wait; $fell(wait_n_o) && !rd_n_i && !cs_n_i |=> wait_n_o && host_data_lines_oe_o; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait without data");
  property p_read_hold; host_data_lines_oe_o && !rd_n_i && !cs_n_i |=> host_data_lines_oe_o && $stable(host_data_lines_o); endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data dropped");
  property p_oe_read; $rose(host_data_lines_oe_o) |-> !rd_n_i && !cs_n_i; endproperty
  a_oe_read: assert property (p_oe_read) else $error("bus driven off a read");
  property p_no_oe_write; (!wr_n_i && rd_n_i)[*4] |-> !host_data_lines_oe_o; endproperty
  a_no_oe_write: assert property (p_no_oe_write) else $error("bus driven in a write");
  property p_sreq_done; $rose(service_request_out_o) |-> done_n_oe_o; endproperty
  a_sreq_done: assert property (p_sreq_done) else $error("sreq rose off completion");
  property p_rd_clear; $fell(wait_n_o) && !rd_n_i && !cs_n_i |-> ##[1:2] !done_n_oe_o; endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read kept done");
  property p_wr_clear; $rose(wr_n_i) && !cs_n_i |-> ##[1:4] !done_n_oe_o; endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write kept done");
  property p_reset_clear; reset_i[*5] |-> !done_n_oe_o && !service_request_out_o; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset kept flags");
endmodule : arith_port_monitor

bind arith_host_port arith_port_monitor u_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reset_i(reset_i), .cs_n_i(cs_n_i),
  .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .host_data_lines_o(host_data_lines_o),
  .host_data_lines_oe_o(host_data_lines_oe_o), .wait_n_o(wait_n_o),
  .done_n_oe_o(done_n_oe_o), .completion_ack_n_i(completion_ack_n_i),
  .service_request_out_o(service_request_out_o), .service_ack_in_n_i(service_ack_in_n_i)
);

//--- arith_port_pkg.sv
// constants shared by the arithmetic coprocessor host port
// assumes a single 25 MHz clock and an active-low asynchronous reset
package arith_port_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SREQ_BIT = 7;
  localparam int unsigned PREC_BIT = 6;
  localparam int unsigned FIXED_BIT = 5;
  // default execution time of one command, in clock cycles
  localparam int unsigned EXEC_CYCLES = 16;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam int unsigned ST_BUSY = 7;
  localparam int unsigned ST_SIGN = 6;
  localparam int unsigned ST_ZERO = 5;
  typedef enum logic [1:0] {
    XFER_PUSH,
    XFER_POP,
    XFER_CMD,
    XFER_STATUS
  } xfer_type;
  typedef enum {
    BUS_IDLE,
    BUS_WR_WAIT,
    BUS_WR_HOLD,
    BUS_RD_HOLD
  } bus_state_type;
endpackage : arith_port_pkg

//--- host_bus_model.sv
// far side: a host doing one bus access per select cycle
// assumes the bench resolves the data wire from both drivers
module host_bus_model (
  input wire logic mclk_i,
  input wire logic wait_n_i,
  input wire logic [7:0] bus_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cmd_data_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cmd_data_o = 1'b0;
    data_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one strobe only, never both fresh select per access
  task automatic access(input logic cd, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdat, output int cyc);
    @(negedge mclk_i);
    cmd_data_o = cd;
    cs_n_o = 1'b0;
    if (!rd) data_o = wd;
    @(negedge mclk_i);
    if (rd) rd_n_o = 1'b0;
    else wr_n_o = 1'b0;
    cyc = 0;
    repeat (4) @(negedge mclk_i);
    // strobe held while wait is low; a write may never show it
    while (wait_n_i !== 1'b1 && cyc < 500) begin
      @(negedge mclk_i);
      cyc++;
    end
    rdat = bus_i;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    @(negedge mclk_i);
    cs_n_o = 1'b1;
    data_o = ~data_o;
    @(negedge mclk_i);
  endtask : access
endmodule : host_bus_model

//--- operand_stack.sv
// byte-addressed operand stack of 16-bit words for the host port
// assumes pushes and pops arrive as single-cycle strobes from the port logic
module operand_stack #(
  parameter int unsigned DEPTH = arith_port_pkg::STACK_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [7:0] wr_byte_i,
  input wire logic pop_shift_i,
  output logic [7:0] top_byte_o,
  output logic [15:0] stack_top_o
);
  import arith_port_pkg::*;

  localparam int unsigned BYTES = DEPTH * 2;
  localparam int unsigned PW = $clog2(BYTES);

  // the stack is held as a byte ring so odd transfer counts just skew alignment
  logic [7:0] mem_ff [BYTES];
  logic [PW-1:0] ptr_ff;
  wire [PW-1:0] ptr_dn = ptr_ff - PW'(1);
  wire [PW-1:0] ptr_up = ptr_ff + PW'(1);
  wire [PW-1:0] ptr_lo = ptr_ff - PW'(2);

  //////////////////////////////////////////////////////////////////////////
  // pointer moves; wraps round like a ring, so overflow overwrites the bottom
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_ff <= '0;
    end else if (push_i) begin
      ptr_ff <= ptr_up;
    end else if (pop_i || pop_shift_i) begin
      ptr_ff <= ptr_dn;
    end
  end

  // storage has no reset, contents after reset are undefined as allowed
  always_ff @(posedge mclk_i) begin
    if (push_i) begin
      mem_ff[ptr_ff] <= wr_byte_i;
    end
  end

  // top byte is the most recent push, which is the msb of the top word
  assign top_byte_o = mem_ff[ptr_dn];
  assign stack_top_o = {mem_ff[ptr_dn], mem_ff[ptr_lo]};
endmodule : operand_stack

//--- tb_top.sv
// bench: host model on the bus, acks and reset pin driven here
// assumes the package, port top, checker and host model are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import arith_port_pkg::*;
  typedef struct {logic cd; logic rd; logic [7:0] wd; logic [7:0] exp;} row_type;
  logic mclk, rst_n, reset, cs_n, rd_n, wr_n, cd, wait_n, oe, done_oe, svc_req, comp_ack_n, svc_ack_n;
  logic [7:0] host_drv, dut_out, bus, rdat;
  int fails = 0;
  int samples_checked = 0;
  int cyc, n;
  // pushes lsb first, pops return msb first
  row_type rows [9] = '{'{1'b0, 1'b0, 8'h34, 8'h00}, '{1'b0, 1'b0, 8'h12, 8'h00},
    '{1'b0, 1'b0, 8'hcd, 8'h00}, '{1'b0, 1'b0, 8'hab, 8'h00}, '{1'b0, 1'b1, 8'h00, 8'hab},
    '{1'b0, 1'b1, 8'h00, 8'hcd}, '{1'b0, 1'b1, 8'h00, 8'h12}, '{1'b0, 1'b1, 8'h00, 8'h34},
    '{1'b1, 1'b1, 8'h00, 8'h00}};
  assign bus = oe ? dut_out : host_drv; // wire level from both drivers
  host_bus_model u_host (.mclk_i(mclk), .wait_n_i(wait_n), .bus_i(bus), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .cmd_data_o(cd), .data_o(host_drv));
  arith_host_port dut (.mclk_i(mclk), .rst_n_i(rst_n), .reset_i(reset), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .cmd_data_i(cd), .host_data_lines_i(bus),
    .host_data_lines_o(dut_out), .host_data_lines_oe_o(oe), .wait_n_o(wait_n), .done_n_o(),
    .done_n_oe_o(done_oe), .completion_ack_n_i(comp_ack_n), .service_request_out_o(svc_req),
    .service_ack_in_n_i(svc_ack_n));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // bounded, since a lost completion must not hang the run; running out is a mismatch
  task automatic wait_done;
    n = 0;
    while (done_oe !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    check("completion in time", 8'(n < 100), 8'h01);
  endtask : wait_done
  initial begin
    #200000;
    fails++;
    summarize();
  end
  initial begin
    {rst_n, reset, comp_ack_n, svc_ack_n} = 4'h3;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    check("reset outputs", {wait_n, oe, done_oe, svc_req}, 8'h08);
    repeat (3) @(negedge mclk);
    foreach (rows[i]) begin
      u_host.access(rows[i].cd, rows[i].rd, rows[i].wd, rdat, cyc);
      check("row wait", 8'(cyc < 500), 8'h01);
      if (rows[i].rd) check("row read", rdat, rows[i].exp);
    end
    $display("test rows ended");
    u_host.access(1'b1, 1'b0, 8'hec, rdat, cyc);
    u_host.access(1'b1, 1'b1, 8'h00, rdat, cyc);
    check("busy status", rdat, 8'(1 << ST_BUSY));
    wait_done();
    check("done and request", {done_oe, svc_req}, 8'h03);
    u_host.access(1'b1, 1'b1, 8'h00, rdat, cyc);
    check("done after read", done_oe, 1'b0);
    svc_ack_n = 1'b0;
    repeat (4) @(negedge mclk);
    svc_ack_n = 1'b1; // released again, never held low for good
    check("request after ack", svc_req, 1'b0);
    $display("test request ended");
    u_host.access(1'b1, 1'b0, 8'hec, rdat, cyc);
    u_host.access(1'b1, 1'b0, 8'h6c, rdat, cyc);
    check("command while busy", cyc > 3, 1'b1);
    // first completion raises the first command's request and releases the parked write; the write rise then clears done
    repeat (2) @(negedge mclk);
    check("request of first command", svc_req, 1'b1);
    check("done after write", done_oe, 1'b0);
    wait_done();
    check("request auto clear", {done_oe, svc_req}, 8'h02);
    comp_ack_n = 1'b0;
    repeat (4) @(negedge mclk);
    u_host.access(1'b1, 1'b0, 8'h6c, rdat, cyc);
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      #1 if (done_oe === 1'b1) n++;
    end
    check("done pulse width", 8'(n), 8'h01);
    comp_ack_n = 1'b1;
    $display("test acknowledge ended");
    // flags set first, then reset lands in a running command so it must stop it
    u_host.access(1'b1, 1'b0, 8'hec, rdat, cyc);
    wait_done();
    check("flags before reset", {done_oe, svc_req}, 8'h03);
    u_host.access(1'b1, 1'b0, 8'hec, rdat, cyc);
    reset = 1'b1;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    repeat (25) @(negedge mclk);
    check("flags after reset", {done_oe, svc_req}, 8'h00);
    u_host.access(1'b1, 1'b1, 8'h00, rdat, cyc);
    check("status after reset", rdat, STATUS_RST);
    $display("test reset pin ended");
    summarize();
  end
endmodule : tb_top
